// ===== rtl/scan_pkg.sv
// Shared constants and types of the trace and boundary-scan port
package scan_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int NPINS      = 4;
  localparam int CHAIN_W    = 3 * NPINS;
  localparam int IR_W       = 2;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [31:0] DEMC_ADDR   = 32'hE000EDFC;
  localparam logic [31:0] STIM0_ADDR  = 32'h00000000;
  localparam logic [31:0] TEN_ADDR    = 32'h00000004;
  localparam logic [31:0] TPR_ADDR    = 32'h00000008;
  localparam logic [31:0] PROTO_ADDR  = 32'h0000000C;
  localparam logic [31:0] FFCR_ADDR   = 32'h00000010;
  localparam logic [31:0] PRESC_ADDR  = 32'h00000014;
  localparam logic [31:0] STATUS_ADDR = 32'h00000018;
  localparam logic [31:0] CHIPID_ADDR = 32'h0000001C;

  // Field positions
  localparam int GTE_BIT = 0;
  localparam int ST_SCAN = 0;
  localparam int ST_TWO  = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_CNT  = 4;
  localparam int CELL_OUT = 0;
  localparam int CELL_IN  = 1;
  localparam int CELL_CTL = 2;

  // Values after reset and encodings
  localparam logic [1:0]  PROTO_MANCH = 2'h1;
  localparam logic [1:0]  PROTO_NRZ   = 2'h2;
  localparam logic [1:0]  PROTO_RST   = PROTO_MANCH;
  localparam logic [31:0] FFCR_RST    = 32'h00000000;
  localparam logic [15:0] PRESC_RST   = 16'h0000;
  localparam logic [IR_W-1:0] IR_EXTEST  = 2'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 2'h1;
  localparam logic [IR_W-1:0] IR_BYPASS  = 2'h3;
  localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;

  // Frame counts: start, eight data bits, stop; four bytes a word
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] DATA_LAST  = 4'h8;
  localparam logic [1:0] BYTE_LAST  = 2'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
    TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum logic [1:0] {TX_IDLE, TX_FRAME} tx_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [2:0]  pprot;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic               strap_done;
    logic               scan_mode;
    logic               two_wire;
    logic               tck_q;
    tap_state_t         tap;
    logic [IR_W-1:0]    ir;
    logic [IR_W-1:0]    ir_sh;
    logic               bypass;
    logic [CHAIN_W-1:0] chain_sh;
    logic [CHAIN_W-1:0] chain_upd;
    logic               tdo_q;
    logic               tdo_en;
    logic               gte;
    logic               ten;
    logic               tpr;
    logic [1:0]         proto;
    logic [31:0]        ffcr;
    logic [15:0]        presc;
    tx_state_t          tx;
    logic [1:0]         byte_idx;
    logic [3:0]         bit_idx;
    logic [31:0]        shreg;
    logic [15:0]        pcnt;
    logic               line;
    logic [31:0]        prdata;
  } top_state_t;

  localparam top_state_t STATE_RST = '{
    tap: TAP_RESET, tx: TX_IDLE, ir: IR_BYPASS, proto: PROTO_RST,
    ffcr: FFCR_RST, presc: PRESC_RST, default: '0};

endpackage : scan_pkg

// ===== rtl/trace_and_boundary_scan_port.sv
// Trace output and boundary-scan test port with its stimulus FIFO
//
// The APB register port is this design's own decision.

// ************************************************************
// Stimulus FIFO
// ************************************************************
module stream_fifo #(
  parameter int  WIDTH = 32,
  parameter int  DEPTH = 16,
  localparam int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  // Fill level
  output logic      [AW:0]      count
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        push;
  logic        pop;

  assign in_ready  = s_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_reg.cnt != '0;
  assign out_data  = s_reg.mem[s_reg.rp];
  assign count     = s_reg.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : stream_fifo

// ************************************************************
// Port top level
// ************************************************************
module trace_and_boundary_scan_port #(
  // Value is arbitrary
  parameter logic [31:0] CHIP_ID = 32'h00000001
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire scan_pkg::apb_req_t          apb_req,
  output scan_pkg::apb_rsp_t               apb_rsp,
  // Power-up straps
  input  wire logic                        test_mode_pin,
  input  wire logic                        port_d_bit0_pin,
  input  wire logic                        scan_select_pin,
  // Test access port
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  // Shared trace / test data out pin
  output logic                             serial_trace_out_pin,
  output logic                             serial_trace_out_oe,
  // Pads and core side of the pads
  input  wire logic [scan_pkg::NPINS-1:0]  pad_in,
  output logic      [scan_pkg::NPINS-1:0]  pad_out,
  output logic      [scan_pkg::NPINS-1:0]  pad_oe,
  input  wire logic [scan_pkg::NPINS-1:0]  core_out,
  input  wire logic [scan_pkg::NPINS-1:0]  core_oe
);
  localparam int CW = $clog2(scan_pkg::FIFO_DEPTH) + 1;

  scan_pkg::top_state_t            s_reg;
  scan_pkg::top_state_t            s_next;
  logic [scan_pkg::CHAIN_W-1:0]    cap_vec;
  logic                            trace_on;
  logic                            extest;
  logic                            setup;
  logic                            access;
  logic [3:0]                      sel;
  logic                            stim_ok;
  logic                            push_valid;
  logic                            fifo_in_ready;
  logic                            fifo_out_valid;
  logic [31:0]                     fifo_out_data;
  logic                            pop_ready;
  logic [CW-1:0]                   fifo_count;
  logic                            tck_rise;
  logic                            tck_fall;
  logic                            tick;
  logic                            first_half;
  logic                            nrz;
  logic                            bit_val;

  // ************************************************************
  // Decoding
  // ************************************************************
  function automatic logic [3:0] reg_sel(input logic [31:0] a);
    unique case (a)
      scan_pkg::STIM0_ADDR:  reg_sel = 4'h0;
      scan_pkg::TEN_ADDR:    reg_sel = 4'h1;
      scan_pkg::TPR_ADDR:    reg_sel = 4'h2;
      scan_pkg::PROTO_ADDR:  reg_sel = 4'h3;
      scan_pkg::FFCR_ADDR:   reg_sel = 4'h4;
      scan_pkg::PRESC_ADDR:  reg_sel = 4'h5;
      scan_pkg::STATUS_ADDR: reg_sel = 4'h6;
      scan_pkg::CHIPID_ADDR: reg_sel = 4'h7;
      scan_pkg::DEMC_ADDR:   reg_sel = 4'h8;
      default:               reg_sel = 4'hF;
    endcase
  endfunction : reg_sel

  function automatic scan_pkg::tap_state_t tap_next(
    input scan_pkg::tap_state_t st,
    input logic                 m
  );
    unique case (st)
      scan_pkg::TAP_RESET:  tap_next = m ? scan_pkg::TAP_RESET
                                         : scan_pkg::TAP_IDLE;
      scan_pkg::TAP_IDLE:   tap_next = m ? scan_pkg::TAP_SEL_DR
                                         : scan_pkg::TAP_IDLE;
      scan_pkg::TAP_SEL_DR: tap_next = m ? scan_pkg::TAP_SEL_IR
                                         : scan_pkg::TAP_CAP_DR;
      scan_pkg::TAP_CAP_DR: tap_next = m ? scan_pkg::TAP_EX1_DR
                                         : scan_pkg::TAP_SH_DR;
      scan_pkg::TAP_SH_DR:  tap_next = m ? scan_pkg::TAP_EX1_DR
                                         : scan_pkg::TAP_SH_DR;
      scan_pkg::TAP_EX1_DR: tap_next = m ? scan_pkg::TAP_UPD_DR
                                         : scan_pkg::TAP_PAU_DR;
      scan_pkg::TAP_PAU_DR: tap_next = m ? scan_pkg::TAP_EX2_DR
                                         : scan_pkg::TAP_PAU_DR;
      scan_pkg::TAP_EX2_DR: tap_next = m ? scan_pkg::TAP_UPD_DR
                                         : scan_pkg::TAP_SH_DR;
      scan_pkg::TAP_UPD_DR: tap_next = m ? scan_pkg::TAP_SEL_DR
                                         : scan_pkg::TAP_IDLE;
      scan_pkg::TAP_SEL_IR: tap_next = m ? scan_pkg::TAP_RESET
                                         : scan_pkg::TAP_CAP_IR;
      scan_pkg::TAP_CAP_IR: tap_next = m ? scan_pkg::TAP_EX1_IR
                                         : scan_pkg::TAP_SH_IR;
      scan_pkg::TAP_SH_IR:  tap_next = m ? scan_pkg::TAP_EX1_IR
                                         : scan_pkg::TAP_SH_IR;
      scan_pkg::TAP_EX1_IR: tap_next = m ? scan_pkg::TAP_UPD_IR
                                         : scan_pkg::TAP_PAU_IR;
      scan_pkg::TAP_PAU_IR: tap_next = m ? scan_pkg::TAP_EX2_IR
                                         : scan_pkg::TAP_PAU_IR;
      scan_pkg::TAP_EX2_IR: tap_next = m ? scan_pkg::TAP_UPD_IR
                                         : scan_pkg::TAP_SH_IR;
      scan_pkg::TAP_UPD_IR: tap_next = m ? scan_pkg::TAP_SEL_DR
                                         : scan_pkg::TAP_IDLE;
    endcase
  endfunction : tap_next

  // ************************************************************
  // Pad cells
  // ************************************************************
  assign extest = s_reg.scan_mode && (s_reg.ir == scan_pkg::IR_EXTEST);

  for (genvar i = 0; i < scan_pkg::NPINS; i++) begin : g_cell
    assign cap_vec[3*i+scan_pkg::CELL_OUT] = core_out[i];
    assign cap_vec[3*i+scan_pkg::CELL_IN]  = pad_in[i];
    assign cap_vec[3*i+scan_pkg::CELL_CTL] = core_oe[i];
    assign pad_out[i] = extest ? s_reg.chain_upd[3*i+scan_pkg::CELL_OUT]
                               : core_out[i];
    assign pad_oe[i]  = extest ? s_reg.chain_upd[3*i+scan_pkg::CELL_CTL]
                               : core_oe[i];
  end

  // ************************************************************
  // Bus and trace datapath
  // ************************************************************
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign access   = apb_req.psel & apb_req.penable;
  assign sel      = reg_sel(apb_req.paddr);
  assign trace_on = s_reg.gte & s_reg.two_wire;
  // pprot[0] set marks a privileged access
  assign stim_ok  = trace_on & s_reg.ten
                  & (~s_reg.tpr | apb_req.pprot[0]);
  assign push_valid = access & apb_req.pwrite & (sel == 4'h0) & stim_ok;
  // A full FIFO stalls the writing master instead of dropping trace
  assign apb_rsp.pready  = ~(push_valid & ~fifo_in_ready);
  assign apb_rsp.pslverr = access & (sel == 4'hF);
  assign apb_rsp.prdata  = s_reg.prdata;
  assign pop_ready = trace_on && (s_reg.tx == scan_pkg::TX_IDLE);

  stream_fifo #(
    .WIDTH (scan_pkg::DATA_W),
    .DEPTH (scan_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (push_valid),
    .in_data   (apb_req.pwdata),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (pop_ready),
    .count     (fifo_count)
  );

  assign tick       = s_reg.pcnt == s_reg.presc;
  assign first_half = s_reg.pcnt <= (s_reg.presc >> 1);
  assign nrz        = s_reg.proto == scan_pkg::PROTO_NRZ;
  assign tck_rise   = tck & ~s_reg.tck_q;
  assign tck_fall   = ~tck & s_reg.tck_q;

  always_comb begin
    s_next       = s_reg;
    s_next.tck_q = tck;
    bit_val      = 1'b0;

    // Straps are read once; only a chip reset can change the mode
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.scan_mode  = test_mode_pin & ~port_d_bit0_pin
                        & scan_select_pin;
      s_next.two_wire   = ~scan_select_pin;
    end

    // Scan controller
    if (s_reg.scan_mode && tck_rise) begin
      if (s_reg.tap == scan_pkg::TAP_RESET) begin
        s_next.ir = scan_pkg::IR_BYPASS;
      end else if (s_reg.tap == scan_pkg::TAP_CAP_DR) begin
        if (s_reg.ir == scan_pkg::IR_BYPASS) begin
          s_next.bypass = 1'b0;
        end else begin
          s_next.chain_sh = cap_vec;
        end
      end else if (s_reg.tap == scan_pkg::TAP_SH_DR) begin
        if (s_reg.ir == scan_pkg::IR_BYPASS) begin
          s_next.bypass = tdi;
        end else begin
          s_next.chain_sh = {tdi,
            s_reg.chain_sh[scan_pkg::CHAIN_W-1:1]};
        end
      end else if (s_reg.tap == scan_pkg::TAP_UPD_DR) begin
        if (s_reg.ir != scan_pkg::IR_BYPASS) begin
          s_next.chain_upd = s_reg.chain_sh;
        end
      end else if (s_reg.tap == scan_pkg::TAP_CAP_IR) begin
        s_next.ir_sh = scan_pkg::IR_CAPTURE;
      end else if (s_reg.tap == scan_pkg::TAP_SH_IR) begin
        s_next.ir_sh = {tdi, s_reg.ir_sh[scan_pkg::IR_W-1:1]};
      end else if (s_reg.tap == scan_pkg::TAP_UPD_IR) begin
        s_next.ir = s_reg.ir_sh;
      end
      s_next.tap = tap_next(s_reg.tap, tms);
    end
    if (s_reg.scan_mode && tck_fall) begin
      s_next.tdo_en = (s_reg.tap == scan_pkg::TAP_SH_DR)
                    || (s_reg.tap == scan_pkg::TAP_SH_IR);
      if (s_reg.tap == scan_pkg::TAP_SH_IR) begin
        s_next.tdo_q = s_reg.ir_sh[0];
      end else if (s_reg.ir == scan_pkg::IR_BYPASS) begin
        s_next.tdo_q = s_reg.bypass;
      end else begin
        s_next.tdo_q = s_reg.chain_sh[0];
      end
    end

    // Register writes take effect at the completing edge
    if (access && apb_req.pwrite && apb_rsp.pready) begin
      if (sel == 4'h8) begin
        s_next.gte = apb_req.pwdata[scan_pkg::GTE_BIT];
      end else if (s_reg.gte) begin
        unique case (sel)
          4'h1: s_next.ten   = apb_req.pwdata[0];
          4'h2: s_next.tpr   = apb_req.pwdata[0];
          4'h3: s_next.proto = apb_req.pwdata[1:0];
          4'h4: s_next.ffcr  = apb_req.pwdata;
          4'h5: s_next.presc = apb_req.pwdata[15:0];
          default: ;
        endcase
      end
    end

    // Read data is registered in the setup cycle
    if (setup && !apb_req.pwrite) begin
      s_next.prdata = '0;
      unique case (sel)
        4'h0: s_next.prdata[0] = fifo_in_ready;
        4'h1: s_next.prdata[0] = s_reg.ten;
        4'h2: s_next.prdata[0] = s_reg.tpr;
        4'h3: s_next.prdata[1:0] = s_reg.proto;
        4'h4: s_next.prdata = s_reg.ffcr;
        4'h5: s_next.prdata[15:0] = s_reg.presc;
        4'h6: begin
          s_next.prdata[scan_pkg::ST_SCAN] = s_reg.scan_mode;
          s_next.prdata[scan_pkg::ST_TWO]  = s_reg.two_wire;
          s_next.prdata[scan_pkg::ST_BUSY] = s_reg.tx != scan_pkg::TX_IDLE;
          s_next.prdata[scan_pkg::ST_CNT +: CW] = fifo_count;
        end
        4'h7: s_next.prdata = s_reg.two_wire ? CHIP_ID : '0;
        4'h8: s_next.prdata[scan_pkg::GTE_BIT] = s_reg.gte;
        default: ;
      endcase
    end

    // Serialiser: each word leaves as four bytes, low byte first
    unique case (s_reg.tx)
      scan_pkg::TX_IDLE: begin
        if (fifo_out_valid && pop_ready) begin
          s_next.shreg    = fifo_out_data;
          s_next.byte_idx = '0;
          s_next.bit_idx  = '0;
          s_next.pcnt     = '0;
          s_next.tx       = scan_pkg::TX_FRAME;
        end
      end
      scan_pkg::TX_FRAME: begin
        s_next.pcnt = tick ? '0 : s_reg.pcnt + 16'h0001;
        if (!trace_on) begin
          s_next.tx = scan_pkg::TX_IDLE;
        end else if (tick) begin
          if (s_reg.bit_idx != '0 && s_reg.bit_idx <= scan_pkg::DATA_LAST) begin
            s_next.shreg = s_reg.shreg >> 1;
          end
          if (s_reg.bit_idx == scan_pkg::FRAME_LAST) begin
            s_next.bit_idx = '0;
            if (s_reg.byte_idx == scan_pkg::BYTE_LAST) begin
              s_next.tx = scan_pkg::TX_IDLE;
            end else begin
              s_next.byte_idx = s_reg.byte_idx + 2'h1;
            end
          end else begin
            s_next.bit_idx = s_reg.bit_idx + 4'h1;
          end
        end
      end
      default: s_next.tx = scan_pkg::TX_IDLE;
    endcase

    // Line coding; Manchester idles low, NRZ idles high
    if (s_reg.tx != scan_pkg::TX_FRAME) begin
      s_next.line = nrz;
    end else if (s_reg.bit_idx == scan_pkg::FRAME_LAST) begin
      s_next.line = nrz;
    end else begin
      if (s_reg.bit_idx == '0) begin
        bit_val = ~nrz;
      end else begin
        bit_val = s_reg.shreg[0];
      end
      // Manchester needs a prescaler of one or more to show two halves
      s_next.line = nrz ? bit_val
                        : (first_half ? bit_val : ~bit_val);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= scan_pkg::STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Shared output pin
  // ************************************************************
  assign serial_trace_out_pin = s_reg.scan_mode ? s_reg.tdo_q
                                                : s_reg.line;
  assign serial_trace_out_oe  = s_reg.scan_mode ? s_reg.tdo_en
                                                : trace_on;

endmodule : trace_and_boundary_scan_port

// ===== bench/trace_port_asserts.sv
// Port-level checker of the trace and boundary-scan port
module trace_port_checker #(
  parameter logic [31:0] CHIP_ID = 32'h00000001
) (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // APB
  input wire scan_pkg::apb_req_t         apb_req,
  input wire scan_pkg::apb_rsp_t         apb_rsp,
  // Straps
  input wire logic                       test_mode_pin,
  input wire logic                       port_d_bit0_pin,
  input wire logic                       scan_select_pin,
  // Pin and pads
  input wire logic                       serial_trace_out_oe,
  input wire logic [scan_pkg::NPINS-1:0] pad_out,
  input wire logic [scan_pkg::NPINS-1:0] pad_oe,
  input wire logic [scan_pkg::NPINS-1:0] core_out,
  input wire logic [scan_pkg::NPINS-1:0] core_oe
);
  logic rd_set;
  logic dem_wr;
  logic scan;
  assign rd_set = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign dem_wr = apb_req.psel & apb_req.penable & apb_req.pwrite
    & apb_rsp.pready & (apb_req.paddr == scan_pkg::DEMC_ADDR);
  assign scan = test_mode_pin & ~port_d_bit0_pin & scan_select_pin;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chip_id_a: assert property (
    rd_set && apb_req.paddr == scan_pkg::CHIPID_ADDR && !scan_select_pin
    |=> apb_rsp.prdata == CHIP_ID) else $error("Chip id read wrong");
  mode_status_a: assert property (
    rd_set && apb_req.paddr == scan_pkg::STATUS_ADDR |=>
    apb_rsp.prdata[scan_pkg::ST_SCAN] == $past(scan)
    && apb_rsp.prdata[scan_pkg::ST_TWO] == !$past(scan_select_pin))
    else $error("Mode status wrong");
  oe_on_a: assert property (
    dem_wr && apb_req.pwdata[0] && !scan_select_pin |=> serial_trace_out_oe)
    else $error("Trace pin not driven after enable");
  oe_rise_a: assert property (
    $rose(serial_trace_out_oe) && !scan_select_pin |-> $past(dem_wr))
    else $error("Trace pin driven without enable");
  pads_core_a: assert property (
    !scan |-> pad_out == core_out && pad_oe == core_oe)
    else $error("Pads not following core");
  rdata_hold_a: assert property (
    !$past(rd_set) |-> $stable(apb_rsp.prdata))
    else $error("Read data changed");
  err_phase_a: assert property (
    apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
    else $error("Error outside access");
  read_ready_a: assert property (
    rd_set ##1 apb_req.penable |-> apb_rsp.pready)
    else $error("Read stalled");
endmodule : trace_port_checker

// ===== bench/trace_probe.sv
// Debug probe model: NRZ byte receiver on the shared trace pin
module trace_probe #(
  parameter int BIT = 4
) (
  input wire logic pclk,
  input wire logic line,
  input wire logic oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  logic [7:0] b;
  logic       prev;
  int         fr_err;
  initial begin
    prev = 1'b1;
    fr_err = 0;
    forever begin
      @(posedge pclk);
      if (oe && prev && !line) begin
        // Sample mid-bit so a one-cycle rate slip still shows
        repeat (BIT / 2) @(posedge pclk);
        if (line !== 1'b0) fr_err++;
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge pclk);
          b[i] = line;
        end
        repeat (BIT) @(posedge pclk);
        if (line !== 1'b1) fr_err++;
        rx_q.push_back(b);
      end
      prev = line;
    end
  end
endmodule : trace_probe

// ===== bench/trace_and_boundary_scan_port_tb.sv
// Self-checking bench of the trace and boundary-scan port
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module trace_and_boundary_scan_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Value is arbitrary
  localparam logic [31:0] ID = 32'h0000A5C3;
  // Chain load: pins 0 and 3 driven high, pins 1 and 2 made outputs
  localparam logic [11:0] PAT = 12'h321;
  logic               pclk, presetn, pin, oe, err;
  logic               tck, tms, tdi, tdo;
  logic [2:0]         st;
  logic [3:0]         cout, coe, pout, poe, pdin;
  logic [11:0]        cap;
  logic [31:0]        rdat;
  scan_pkg::apb_req_t req;
  scan_pkg::apb_rsp_t rsp;
  int                 err_total, comparisons, cyc;
  trace_and_boundary_scan_port #(.CHIP_ID(ID)) u_trace_and_boundary_scan_port (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .test_mode_pin(st[2]), .port_d_bit0_pin(st[1]), .scan_select_pin(st[0]),
    .tck(tck), .tms(tms), .tdi(tdi), .serial_trace_out_pin(pin),
    .serial_trace_out_oe(oe), .pad_in(pdin), .pad_out(pout), .pad_oe(poe),
    .core_out(cout), .core_oe(coe));
  trace_probe #(.BIT(4)) u_trace_probe (.pclk(pclk), .line(pin), .oe(oe));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [31:0] a, d,
                     input logic [2:0] p);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, pprot: p, paddr: a,
             pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 3'h1);
  endtask : wr
  task automatic rd(input logic [31:0] a, e);
    apb(1'b0, a, 32'h00000000, 3'h1);
    `CHK(rdat, e)
  endtask : rd
  // One test clock: each level held two pclk cycles, tdo taken at the rise
  task automatic tclk(input logic m, d);
    tms <= m;
    tdi <= d;
    repeat (2) @(posedge pclk);
    tdo = pin;
    tck <= 1'b1;
    repeat (2) @(posedge pclk);
    tck <= 1'b0;
  endtask : tclk
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    presetn = 1'b0;
    st = 3'h0; // Two-wire straps held until the chip reset that sets the scan straps
    req = '0;
    cout = 4'hA;
    coe = 4'h3;
    {tck, tms, tdi} = '0;
    pdin = 4'hA;
    {err_total, comparisons, cyc} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(scan_pkg::PROTO_ADDR, 32'h00000001);
    wr(scan_pkg::PROTO_ADDR, 32'h00000002);
    rd(scan_pkg::PROTO_ADDR, 32'h00000001);
    rd(scan_pkg::DEMC_ADDR, 32'h00000000);
    wr(scan_pkg::DEMC_ADDR, 32'h00000001);
    rd(scan_pkg::DEMC_ADDR, 32'h00000001);
    rd(scan_pkg::CHIPID_ADDR, ID);
    rd(scan_pkg::STATUS_ADDR, 32'h00000002);
    wr(scan_pkg::FFCR_ADDR, 32'h00000100);
    rd(scan_pkg::FFCR_ADDR, 32'h00000100);
    wr(scan_pkg::PRESC_ADDR, 32'h00000003);
    wr(scan_pkg::PROTO_ADDR, 32'h00000002);
    rd(scan_pkg::PROTO_ADDR, 32'h00000002);
    wr(scan_pkg::TPR_ADDR, 32'h00000001);
    wr(scan_pkg::TEN_ADDR, 32'h00000001);
    // A user-mode word must be dropped, or byte 0 below goes wrong
    apb(1'b1, scan_pkg::STIM0_ADDR, 32'hFFFFFFFF, 3'h0);
    for (int i = 0; i < 17; i++)
      wr(scan_pkg::STIM0_ADDR, {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)});
    rd(scan_pkg::STIM0_ADDR, 32'h00000000);
    cout <= 4'h5;
    @(posedge pclk);
    `CHK(pout, 4'h5)
    wr(scan_pkg::STIM0_ADDR, 32'h47464544);
    apb(1'b0, 32'h00000040, 32'h00000000, 3'h1);
    `CHK(err, 1'b1)
    while (u_trace_probe.rx_q.size() < 72) @(posedge pclk);
    for (int j = 0; j < 72; j++)
      `CHK(u_trace_probe.rx_q[j], 8'(j))
    `CHK(u_trace_probe.fr_err, 0)
    // A new strap setting only takes hold through a chip reset
    presetn <= 1'b0;
    st <= 3'h5;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(scan_pkg::STATUS_ADDR, 32'h00000001);
    rd(scan_pkg::CHIPID_ADDR, 32'h00000000);
    // Idle, select-DR, capture-DR, shift-DR under BYPASS
    tclk(1'b0, 1'b0);
    tclk(1'b1, 1'b0);
    tclk(1'b0, 1'b0);
    tclk(1'b0, 1'b0);
    tclk(1'b0, 1'b1);
    `CHK(tdo, 1'b0)
    tclk(1'b1, 1'b0);
    `CHK(tdo, 1'b1)
    // Update-DR, select-DR, select-IR, capture-IR, shift-IR
    repeat (3) tclk(1'b1, 1'b0);
    repeat (2) tclk(1'b0, 1'b0);
    // Shift in EXTEST, then update-IR and idle
    tclk(1'b0, 1'b0);
    repeat (2) tclk(1'b1, 1'b0);
    tclk(1'b0, 1'b0);
    // Select-DR, capture-DR, then twelve shifts, the last one exiting
    tclk(1'b1, 1'b0);
    repeat (2) tclk(1'b0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      tclk(i == 11, PAT[i]);
      cap[i] = tdo;
    end
    `CHK(cap, 12'h475)
    tclk(1'b1, 1'b0);
    tclk(1'b0, 1'b0);
    `CHK(pout, 4'h9)
    `CHK(poe, 4'h6)
    report_and_stop();
  end
endmodule : trace_and_boundary_scan_port_tb
bind trace_and_boundary_scan_port trace_port_checker #(.CHIP_ID(CHIP_ID))
  u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .test_mode_pin(test_mode_pin),
  .port_d_bit0_pin(port_d_bit0_pin), .scan_select_pin(scan_select_pin),
  .serial_trace_out_oe(serial_trace_out_oe), .pad_out(pad_out),
  .pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe));
